// file: logic/arf_pkg.sv
package arf_pkg;
	// Register byte addresses (printed offset 0x07 is not a multiple of four)
	localparam logic [7:0] ARF_IDX_INPUT_REF_SEL = 8'h07;
	localparam logic [11:0] ARF_ADDR_INPUT_REF_SEL = {2'h0, ARF_IDX_INPUT_REF_SEL, 2'h0};
	localparam logic [11:0] ARF_ADDR_CTRL_B = 12'h020;
	localparam logic [11:0] ARF_ADDR_RESULT_LOW = 12'h024;
	localparam logic [11:0] ARF_ADDR_RESULT_HIGH = 12'h028;
	localparam logic [11:0] ARF_ADDR_IRQ_STATUS = 12'h02C;
	localparam logic [11:0] ARF_ADDR_IRQ_MASK = 12'h030;
	localparam logic [11:0] ARF_ADDR_ACTIVE_SEL = 12'h034;
	// Reset values
	localparam logic [7:0] ARF_INPUT_REF_SEL_RST = 8'h00;
	localparam logic [9:0] ARF_RESULT_RST = 10'h000;
	// Field positions
	localparam int ARF_REF_HI_BIT = 7;
	localparam int ARF_REF_LO_BIT = 6;
	localparam int ARF_POL_REV_BIT = 5;
	localparam int ARF_GAIN_BIT = 0;
	localparam int ARF_BIPOLAR_BIT = 7;
	localparam int ARF_IRQ_DONE_BIT = 0;
	// Encodings
	localparam logic [5:0] ARF_CH_TEMP_SENSOR = 6'h22;
	localparam logic [5:0] ARF_CH_DIFF_FIRST = 6'h08;
	localparam logic [5:0] ARF_CH_DIFF_LAST = 6'h1F;
	localparam logic [5:0] ARF_CH_REV_FIRST = 6'h28;
	localparam logic [1:0] ARF_REF_SUPPLY = 2'h0;
	localparam logic [1:0] ARF_REF_EXTERNAL = 2'h1;
	localparam logic [1:0] ARF_REF_INTERNAL = 2'h2;
	localparam logic [1:0] ARF_REF_INT_ON_PIN = 2'h3;
	// Scale factors
	localparam int ARF_FULL_SCALE = 1024;
	localparam int ARF_HALF_SCALE = 512;
	localparam int ARF_GAIN_HIGH = 20;
	localparam logic [9:0] ARF_CODE_MAX = 10'h3FF;
	localparam logic [9:0] ARF_BIP_MAX = 10'h1FF;
	localparam logic [9:0] ARF_BIP_MIN = 10'h200;
	typedef enum logic [0:0] {ARF_IDLE, ARF_CONVERT} arf_state_t;
endpackage

// file: logic/arf_ctrl.sv
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
// Summary of operation
// - Single-ended code is vin*1024/vref, 0x000 ground, 0x3FF top.
// - Unipolar differential clamps negative difference to zero.
// - Unipolar differential code is diff*1024*gain/vref, 0 to 1023.
// - Bipolar code is two's complement diff*512*gain/vref, 0x200 to 0x1FF.
// - Differential gain is unity or twenty in both modes.
// - In bipolar mode result bit 9 is the sign for differential channels; single-ended results stay unipolar.
// - Unipolar after reset; bipolar select bit in control B selects bipolar.
// - Channel code 100010 routes and enables the temperature sensor.
// - Reference change during conversion takes effect after completion.
// - Reference codes: 00 supply, 01 external pin, 10 internal 1.1V, 11 internal 1.1V on reference pin.
// - Internal reference drives the reference pin only for code 11.
// - Lowest channel bit selects differential gain: 0 unity, 1 twenty; single-ended channels ignore it.
// - Channel change during conversion is deferred until completion.
// - Result registers are loaded when the done flag rises.
module arf_ctrl
	import arf_pkg::*;
#(
	parameter int VIN_W = 16 // Width of analog magnitude words
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic conv_start, // Start pulse from trigger logic
	input wire logic conv_end, // Analog core finished sampling
	input wire logic [VIN_W-1:0] vin_pos, // Positive input level
	input wire logic [VIN_W-1:0] vin_neg, // Negative input level
	input wire logic [VIN_W-1:0] vref_level, // Selected reference level
	output logic [5:0] active_channel, // Channel in use by converter
	output logic diff_active, // Active channel is differential
	output logic [1:0] active_reference, // Reference in use
	output logic temp_sensor_enable, // Temperature sensor on
	output logic internal_ref_enable, // Internal 1.1V reference on
	output logic external_ref_pin_connect, // Internal ref drives reference pin
	output logic supply_ref_select, // Supply used as reference
	output logic conversion_busy, // Conversion in progress
	output logic conversion_done_flag, // Completion pulse
	output logic irq // Interrupt level
);
	initial begin
		if (VIN_W < 2 || VIN_W > 24) begin
			$error("VIN_W out of range");
		end
	end

	localparam int PROD_W = VIN_W + 16;

	arf_state_t state_q;
	logic [7:0] sel_q;
	logic [7:0] act_q;
	logic bipolar_q;
	logic [9:0] result_q;
	logic done_q;
	logic irq_stat_q;
	logic irq_mask_q;
	logic [9:0] code_d;

	function automatic logic is_diff(input logic [5:0] ch);
		is_diff = (ch >= ARF_CH_DIFF_FIRST && ch <= ARF_CH_DIFF_LAST) || ch >= ARF_CH_REV_FIRST;
	endfunction

	wire wr_en = psel && penable && pwrite;
	wire rd_acc = psel && penable && !pwrite;
	wire done_evt = (state_q == ARF_CONVERT) && conv_end;

	// APB register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= ARF_INPUT_REF_SEL_RST;
			bipolar_q <= 1'b0;
			irq_mask_q <= 1'b0;
		end else if (wr_en) begin
			if (paddr == ARF_ADDR_INPUT_REF_SEL) begin
				sel_q <= pwdata[7:0];
			end
			if (paddr == ARF_ADDR_CTRL_B) begin
				bipolar_q <= pwdata[ARF_BIPOLAR_BIT];
			end
			if (paddr == ARF_ADDR_IRQ_MASK) begin
				irq_mask_q <= pwdata[ARF_IRQ_DONE_BIT];
			end
		end
	end

	// Conversion state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ARF_IDLE;
		end else begin
			unique case (state_q)
				ARF_IDLE: begin
					if (conv_start) begin
						state_q <= ARF_CONVERT;
					end
				end
				ARF_CONVERT: begin
					if (conv_end) begin
						state_q <= ARF_IDLE;
					end
				end
			endcase
		end
	end

	// Active selection copies the register only while idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_q <= ARF_INPUT_REF_SEL_RST;
		end else if (state_q == ARF_IDLE && !conv_start) begin
			act_q <= sel_q;
		end
	end

	// Result encoding
	always_comb begin
		logic [PROD_W-1:0] mag;
		logic [PROD_W-1:0] num;
		logic [PROD_W-1:0] quo;
		logic neg;
		logic [PROD_W-1:0] gain;
		mag = '0;
		num = '0;
		quo = '0;
		neg = 1'b0;
		gain = act_q[ARF_GAIN_BIT] ? PROD_W'(ARF_GAIN_HIGH) : PROD_W'(1);
		code_d = ARF_RESULT_RST;
		if (!is_diff(act_q[5:0])) begin
			num = PROD_W'(vin_pos) * PROD_W'(ARF_FULL_SCALE);
			quo = (vref_level == '0) ? '1 : num / PROD_W'(vref_level);
			code_d = (quo > PROD_W'(ARF_CODE_MAX)) ? ARF_CODE_MAX : quo[9:0];
		end else begin
			neg = vin_neg > vin_pos;
			mag = neg ? PROD_W'(vin_neg - vin_pos) : PROD_W'(vin_pos - vin_neg);
			if (!bipolar_q) begin
				if (neg) begin
					code_d = ARF_RESULT_RST;
				end else begin
					num = mag * PROD_W'(ARF_FULL_SCALE) * gain;
					quo = (vref_level == '0) ? '1 : num / PROD_W'(vref_level);
					code_d = (quo > PROD_W'(ARF_CODE_MAX)) ? ARF_CODE_MAX : quo[9:0];
				end
			end else begin
				num = mag * PROD_W'(ARF_HALF_SCALE) * gain;
				quo = (vref_level == '0) ? '1 : num / PROD_W'(vref_level);
				if (!neg) begin
					code_d = (quo > PROD_W'(ARF_BIP_MAX)) ? ARF_BIP_MAX : quo[9:0];
				end else if (quo >= PROD_W'(ARF_HALF_SCALE)) begin
					code_d = ARF_BIP_MIN;
				end else begin
					code_d = 10'(~quo[9:0] + 10'h001);
				end
			end
		end
	end

	// Result and done pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q <= ARF_RESULT_RST;
			done_q <= 1'b0;
		end else begin
			done_q <= done_evt;
			if (done_evt) begin
				result_q <= code_d;
			end
		end
	end

	// Sticky completion status, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 1'b0;
		end else if (done_evt) begin
			irq_stat_q <= 1'b1;
		end else if (wr_en && paddr == ARF_ADDR_IRQ_STATUS && pwdata[ARF_IRQ_DONE_BIT]) begin
			irq_stat_q <= 1'b0;
		end
	end

	// Read mux
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_acc) begin
			unique case (paddr)
				ARF_ADDR_INPUT_REF_SEL: prdata = {24'h000000, sel_q};
				ARF_ADDR_CTRL_B: prdata = {24'h000000, bipolar_q, 7'h00};
				ARF_ADDR_RESULT_LOW: prdata = {24'h000000, result_q[7:0]};
				ARF_ADDR_RESULT_HIGH: prdata = {30'h00000000, result_q[9:8]};
				ARF_ADDR_IRQ_STATUS: prdata = {31'h00000000, irq_stat_q};
				ARF_ADDR_IRQ_MASK: prdata = {31'h00000000, irq_mask_q};
				ARF_ADDR_ACTIVE_SEL: prdata = {23'h000000, conversion_busy, act_q};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == ARF_ADDR_INPUT_REF_SEL
		|| paddr == ARF_ADDR_CTRL_B || paddr == ARF_ADDR_RESULT_LOW
		|| paddr == ARF_ADDR_RESULT_HIGH || paddr == ARF_ADDR_IRQ_STATUS
		|| paddr == ARF_ADDR_IRQ_MASK || paddr == ARF_ADDR_ACTIVE_SEL);

	assign active_channel = act_q[5:0];
	assign diff_active = is_diff(act_q[5:0]);
	assign active_reference = act_q[ARF_REF_HI_BIT:ARF_REF_LO_BIT];
	assign temp_sensor_enable = act_q[5:0] == ARF_CH_TEMP_SENSOR;
	assign supply_ref_select = active_reference == ARF_REF_SUPPLY;
	assign internal_ref_enable = active_reference == ARF_REF_INTERNAL
		|| active_reference == ARF_REF_INT_ON_PIN;
	assign external_ref_pin_connect = active_reference == ARF_REF_INT_ON_PIN;
	assign conversion_busy = state_q == ARF_CONVERT;
	assign conversion_done_flag = done_q;
	assign irq = irq_stat_q && irq_mask_q;
endmodule // arf_ctrl

// file: verification/arf_ctrl_asserts.sv
`timescale 1ns/100ps
module arf_ctrl_asserts
	import arf_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic conv_start, // Start
	input wire logic conv_end, // End
	input wire logic [5:0] active_channel, // Channel
	input wire logic [1:0] active_reference, // Reference
	input wire logic temp_sensor_enable, // Sensor
	input wire logic internal_ref_enable, // Int ref
	input wire logic external_ref_pin_connect, // Ref pin
	input wire logic supply_ref_select, // Supply
	input wire logic conversion_busy, // Busy
	input wire logic conversion_done_flag // Done
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ts; temp_sensor_enable == (active_channel == ARF_CH_TEMP_SENSOR); endproperty
	a_ts: assert property (p_ts) else $error("sensor");
	property p_pin; external_ref_pin_connect == (active_reference == 2'h3); endproperty
	a_pin: assert property (p_pin) else $error("ref pin");
	property p_ref; internal_ref_enable == active_reference[1] && supply_ref_select == (active_reference == 2'h0); endproperty
	a_ref: assert property (p_ref) else $error("ref decode");
	property p_hr; $past(conversion_busy) && conversion_busy |-> $stable(active_reference); endproperty
	a_hr: assert property (p_hr) else $error("ref moved");
	property p_hc; $past(conversion_busy) && conversion_busy |-> $stable(active_channel); endproperty
	a_hc: assert property (p_hc) else $error("channel moved");
	property p_dn; conv_end && conversion_busy |=> conversion_done_flag && !conversion_busy; endproperty
	a_dn: assert property (p_dn) else $error("no done");
	property p_pl; conversion_done_flag |=> !conversion_done_flag; endproperty
	a_pl: assert property (p_pl) else $error("long done");
	property p_st; conv_start && !conversion_busy |=> conversion_busy; endproperty
	a_st: assert property (p_st) else $error("no start");
	c_dn: cover property (conversion_done_flag);
	c_ts: cover property (temp_sensor_enable && conversion_busy);
	c_pin: cover property (external_ref_pin_connect && conversion_busy);
endmodule // arf_ctrl_asserts
bind arf_ctrl arf_ctrl_asserts i_chk (.*);

// file: verification/arf_analog_model.sv
`timescale 1ns/100ps
module arf_analog_model #(
	parameter logic [15:0] LV [5] = '{16'hC000, 16'h9000, 16'h4000, 16'h4000, 16'h1200}
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic conversion_busy, // Busy
	input wire logic [1:0] active_reference, // Reference
	input wire logic temp_sensor_enable, // Sensor on
	input wire logic [15:0] pos_in, // Pin level
	input wire logic [4:0] lat, // Sample length
	output logic conv_end, // Sample done
	output logic [15:0] vin_pos, // Level seen
	output logic [15:0] vref_level // Reference seen
);
	logic [4:0] cnt_q;
	assign vin_pos = temp_sensor_enable ? LV[4] : pos_in;
	assign vref_level = LV[active_reference];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 5'h00;
			conv_end <= 1'h0;
		end else begin
			cnt_q <= conversion_busy ? cnt_q + 5'h01 : 5'h00;
			conv_end <= conversion_busy && cnt_q == lat;
		end
	end
endmodule // arf_analog_model

// file: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import arf_pkg::*;
	localparam logic [15:0] LV [5] = '{16'hC000, 16'h9000, 16'h4000, 16'h4000, 16'h1200};
	localparam logic [5:0] CH [5] = '{6'h03, 6'h22, 6'h08, 6'h09, 6'h29};
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_start = 0, se;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [15:0] pos_in = 0, vin_neg = 0, vin_pos, vref_level;
	logic [4:0] lat = 5'h06;
	logic pready, pslverr, conv_end, diff_active, temp_sensor_enable, internal_ref_enable;
	logic external_ref_pin_connect, supply_ref_select, conversion_busy, conversion_done_flag, irq;
	logic [5:0] active_channel;
	logic [1:0] active_reference;
	int errors = 0, tests_run = 0, seed = 88, k;
	arf_ctrl i_dut (.*);
	arf_analog_model #(.LV(LV)) i_ana (.*);
	initial forever #5 pclk = ~pclk;
	task automatic end_sim;
		$display("Tests %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	function automatic logic [9:0] ex(input logic [5:0] c, input logic b, input int p, n, v);
		int g, m, a;
		logic d;
		d = (c >= 6'h08 && c <= 6'h1F) || c >= 6'h28;
		g = (d && c[0]) ? 20 : 1;
		m = d ? p - n : p;
		a = (m < 0 ? -m : m) * (b && d ? 512 : 1024) * g / v;
		if (!(b && d)) return (m < 0) ? 10'h000 : (a > 1023 ? 10'h3FF : 10'(a));
		if (m < 0) return (a > 511) ? 10'h200 : 10'(-a);
		return (a > 511) ? 10'h1FF : 10'(a);
	endfunction
	initial begin
		logic [5:0] c;
		logic [1:0] f;
		logic [9:0] e;
		logic b;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		apb(ARF_ADDR_INPUT_REF_SEL, 1'h0, 32'h0);
		chk(r | supply_ref_select, 32'h1);
		apb(ARF_ADDR_CTRL_B, 1'h0, 32'h0);
		chk(r, 32'h0);
		apb(12'h3FC, 1'h0, 32'h0);
		chk(r, 32'h0);
		chk(se, 1'h1);
		for (int i = 0; i < 30; i++) begin
			c = CH[$unsigned($random(seed)) % 5];
			f = (c == 6'h22) ? ARF_REF_INTERNAL : 2'($random(seed));
			b = $random(seed);
			pos_in <= (i == 0) ? 16'hFFFF : 16'($random(seed));
			vin_neg <= 16'($random(seed));
			lat <= 5'h06 + 5'(i % 7);
			apb(ARF_ADDR_CTRL_B, 1'h1, {24'h0, b, 7'h0});
			apb(ARF_ADDR_IRQ_MASK, 1'h1, 32'(i % 2));
			apb(ARF_ADDR_INPUT_REF_SEL, 1'h1, {24'h0, f, c});
			repeat (13) @(posedge pclk);
			chk(external_ref_pin_connect, f == 2'h3);
			chk({active_reference, active_channel}, {f, c});
			chk(diff_active, (c >= 6'h08 && c <= 6'h1F) || c >= 6'h28);
			conv_start <= 1'h1;
			@(posedge pclk);
			conv_start <= 1'h0;
			apb(ARF_ADDR_INPUT_REF_SEL, 1'h1, {24'h0, ~f, ~c});
			for (k = 0; k < 40 && conversion_done_flag !== 1'h1; k++) @(posedge pclk);
			chk({conversion_done_flag, irq}, {1'h1, 1'(i % 2)});
			e = ex(c, b, (c == 6'h22) ? LV[4] : pos_in, vin_neg, LV[f]);
			apb(ARF_ADDR_IRQ_STATUS, 1'h1, 32'h1);
			apb(ARF_ADDR_RESULT_LOW, 1'h0, 32'h0);
			chk({r, irq}, {e[7:0], 1'h0});
			apb(ARF_ADDR_RESULT_HIGH, 1'h0, 32'h0);
			chk(r, e[9:8]);
			chk(se, 1'h0);
			$display("Test %0d done ch %h ref %h bip %b", i, c, f, b);
		end
		end_sim;
	end
	initial begin
		repeat (6000) @(posedge pclk);
		errors++;
		end_sim;
	end
endmodule // tb_top
